// [include/adc_consts.svh]
/*
  timing counts, word layout and receiver sizes shared by both ends of the converter link.
  assumes mclk at 200 MHz on both ends; included by bare name.
*/
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// ************
// word layout
// ************
`define ADC_WORD_BITS 14
`define ADC_WORD_SLOTS 14
`define ADC_LAST_SLOT 4'hD
`define ADC_HALF_SLOT 4'h7
`define ADC_MIDSCALE 16'h2000

// ************
// timing
// ************
`define ADC_MCLK_NS 5
`define ADC_SLOT_CYCLES 4
`define ADC_PH_LAST 2'h3
`define ADC_PH_CLK 2'h1
`define ADC_PAR_HALF 3'h3
`define ADC_WORD_NS (`ADC_WORD_SLOTS * `ADC_SLOT_CYCLES * `ADC_MCLK_NS)
`define ADC_SINGLE_MAX_MSPS 65
`define ADC_SINGLE_MSPS (1000 / `ADC_WORD_NS)

// ************
// receiver sizes
// ************
`define ADC_AVG_DEPTH 8
`define ADC_AVG_SHIFT 3
`define ADC_BUF_DEPTH 512

`endif

// [include/adc_pkg.sv]
/*
  types shared by both ends of the converter link.
  assumes nothing beyond a SystemVerilog compiler.
*/
package adc_pkg;
  // output format of the converter, also what the receiver expects
  typedef enum logic [1:0] {
    ADC_MODE_PAR,
    ADC_MODE_SINGLE,
    ADC_MODE_DUAL_ALIGNED,
    ADC_MODE_DUAL_OFFSET
  } adc_mode_t;
endpackage : adc_pkg

// [include/adc_link_if.sv]
/*
  the wires between converter and receiver: parallel bus plus serial lanes.
  assumes the converter drives every signal; the bench joins the two modports.
*/
`timescale 1ns/1ps
interface adc_link_if;
  logic [13:0] par_data;
  logic par_ovr;
  logic sample_valid_strobe;
  logic bit_clk;
  logic frame;
  logic serial_lane_zero;
  logic serial_lane_one;

  modport conv (
    output par_data,
    output par_ovr,
    output sample_valid_strobe,
    output bit_clk,
    output frame,
    output serial_lane_zero,
    output serial_lane_one
  );

  modport rcv (
    input par_data,
    input par_ovr,
    input sample_valid_strobe,
    input bit_clk,
    input frame,
    input serial_lane_zero,
    input serial_lane_one
  );
endinterface : adc_link_if

// [hw/adc_conv_end.sv]
/*
  converter end: turns conversion results into the parallel or serial link format,
  making the strobe and the bit clock from mclk by dividers.
  assumes sample_data/sample_ovr are synchronous to mclk and always hold a fresh result.
*/
// Functional notes
// - parallel output is a 14-bit word
// - data changes on strobe fall, latched on rise
// - parallel link moves one word per strobe period
// - strobe toggles at the sample rate
// - over-range flag goes out with the strobe
// - serial link sends 14-bit words on lanes
// - bit clock is forwarded in phase with data; here it toggles mid slot, each edge centred on a bit
// - serial data uses both bit clock edges
// - frame marker marks the start of words
// - receiver shifts frame timing to meet windows; here frame takes the same two flops as the data, unshifted
// - single lane only up to 65 MSPS
// - each dual lane carries half the rate
// - dual lane: first sample lane one, alternate
// - receiver reorders dual lane samples correctly
// - aligned dual: both words on frame rise
// - offset dual: lane one rise, lane zero fall
// - optional 8-sample average in engineering units
// - single lane word spans seven bit clocks
// - receiver loads word register on frame rise
// - receiver buffer keeps first 512 samples only
`timescale 1ns/1ps
`include "adc_consts.svh"

module adc_conv_end
  import adc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire adc_mode_t mode,
  input wire logic [13:0] sample_data,
  input wire logic sample_ovr,
  output logic sample_take,
  output adc_mode_t mode_active,
  adc_link_if.conv link
);

  // ********************
  // rate check
  // ********************
  // single lane is refused above its rate limit and falls back to aligned dual lane
  localparam bit SINGLE_OK = (`ADC_SINGLE_MSPS <= `ADC_SINGLE_MAX_MSPS);

  adc_mode_t mode_reg;
  adc_mode_t eff_mode;
  adc_mode_t word_mode;
  logic [1:0] ph_reg;
  logic [3:0] slot_reg;
  logic [3:0] new_slot;
  logic slot_end;
  logic word_start;
  logic half_start;
  logic bit_clk_reg;
  logic frame_reg;
  logic [13:0] lane0_sr_reg;
  logic [13:0] lane1_sr_reg;
  logic [13:0] hold_reg;
  logic [2:0] par_cnt_reg;
  logic strobe_reg;
  logic [13:0] par_data_reg;
  logic par_ovr_reg;
  logic take_reg;
  logic par_fall;
  logic live_reg;

  // effective mode and slot bookkeeping
  always_comb begin
    eff_mode = mode;
    if (mode == ADC_MODE_SINGLE && !SINGLE_OK) begin
      eff_mode = ADC_MODE_DUAL_ALIGNED;
    end
  end

  assign slot_end = (ph_reg == `ADC_PH_LAST);
  assign new_slot = (slot_reg == `ADC_LAST_SLOT) ? 4'h0 : slot_reg + 4'h1;
  assign word_start = slot_end && (new_slot == 4'h0);
  assign half_start = slot_end && (new_slot == `ADC_HALF_SLOT);
  // a new mode applies from the word it opens, except the aligned dual hold_reg load and take, which follow eff_mode at once
  assign word_mode = word_start ? eff_mode : mode_reg;
  assign par_fall = strobe_reg && (par_cnt_reg == `ADC_PAR_HALF - 3'h1);

  // ********************
  // bit slot timing
  // ********************
  // each bit slot is four mclk cycles; slot 13 at reset so the first word opens after one slot
  always_ff @(posedge mclk) begin
    if (reset) begin
      ph_reg <= 2'h0;
      slot_reg <= `ADC_LAST_SLOT;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      if (slot_end) begin
        slot_reg <= new_slot;
      end
    end
  end

  // mode latched at word boundaries
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_reg <= ADC_MODE_PAR;
    end else if (word_start) begin
      mode_reg <= eff_mode;
    end
  end

  // ********************
  // forwarded bit clock and frame
  // ********************
  // clock toggles mid slot, so each edge sits in the centre of a stable bit
  always_ff @(posedge mclk) begin
    if (reset) begin
      bit_clk_reg <= 1'b0;
    end else if (mode_reg == ADC_MODE_PAR) begin
      bit_clk_reg <= 1'b0;
    end else if (ph_reg == `ADC_PH_CLK) begin
      bit_clk_reg <= ~bit_clk_reg;
    end
  end

  // frame high for slots 0..6, low for 7..13: fourteen toggles, seven clock periods
  always_ff @(posedge mclk) begin
    if (reset) begin
      frame_reg <= 1'b0;
    end else if (word_start) begin
      frame_reg <= (word_mode != ADC_MODE_PAR);
    end else if (half_start) begin
      frame_reg <= 1'b0;
    end
  end

  // ********************
  // lane shifters
  // ********************
  // lane zero: single lane words, or the second sample of a dual pair
  always_ff @(posedge mclk) begin
    if (reset) begin
      lane0_sr_reg <= 14'h0000;
    end else if (slot_end) begin
      if (word_start && word_mode == ADC_MODE_SINGLE) begin
        lane0_sr_reg <= sample_data;
      end else if (word_start && word_mode == ADC_MODE_DUAL_ALIGNED) begin
        lane0_sr_reg <= sample_data;
      end else if (half_start && mode_reg == ADC_MODE_DUAL_OFFSET) begin
        lane0_sr_reg <= sample_data;
      end else begin
        lane0_sr_reg <= {lane0_sr_reg[12:0], 1'b0};
      end
    end
  end

  // lane one: first sample of each dual pair
  always_ff @(posedge mclk) begin
    if (reset) begin
      lane1_sr_reg <= 14'h0000;
    end else if (slot_end) begin
      if (word_start && word_mode == ADC_MODE_DUAL_ALIGNED) begin
        lane1_sr_reg <= hold_reg;
      end else if (word_start && word_mode == ADC_MODE_DUAL_OFFSET) begin
        lane1_sr_reg <= sample_data;
      end else begin
        lane1_sr_reg <= {lane1_sr_reg[12:0], 1'b0};
      end
    end
  end

  // aligned dual mode: the earlier sample of a pair is taken half a word ahead
  // so the two go out together while still keeping conversion order
  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_reg <= 14'h0000;
    end else if (half_start && eff_mode == ADC_MODE_DUAL_ALIGNED) begin
      hold_reg <= sample_data;
    end
  end

  // ********************
  // parallel strobe and bus
  // ********************
  // the mode register only means something after the first word boundary;
  // without this the strobe would run a short pulse before a serial mode takes over
  always_ff @(posedge mclk) begin
    if (reset) begin
      live_reg <= 1'b0;
    end else if (word_start) begin
      live_reg <= 1'b1;
    end
  end

  // strobe period is twice the half count; one word per period
  always_ff @(posedge mclk) begin
    if (reset) begin
      par_cnt_reg <= 3'h0;
      strobe_reg <= 1'b0;
    end else if (mode_reg != ADC_MODE_PAR || !live_reg) begin
      par_cnt_reg <= 3'h0;
      strobe_reg <= 1'b0;
    end else if (par_cnt_reg == `ADC_PAR_HALF - 3'h1) begin
      par_cnt_reg <= 3'h0;
      strobe_reg <= ~strobe_reg;
    end else begin
      par_cnt_reg <= par_cnt_reg + 3'h1;
    end
  end

  // bus and over-range change only as the strobe falls
  always_ff @(posedge mclk) begin
    if (reset) begin
      par_data_reg <= 14'h0000;
      par_ovr_reg <= 1'b0;
    end else if (par_fall) begin
      par_data_reg <= sample_data;
      par_ovr_reg <= sample_ovr;
    end
  end

  // ********************
  // sample consumption
  // ********************
  // one pulse per sample consumed, so the user side sees the true sample rate
  always_ff @(posedge mclk) begin
    if (reset) begin
      take_reg <= 1'b0;
    end else begin
      take_reg <= par_fall && mode_reg == ADC_MODE_PAR
        || word_start && word_mode == ADC_MODE_SINGLE
        || (word_start || half_start) && (word_mode == ADC_MODE_DUAL_OFFSET
        || eff_mode == ADC_MODE_DUAL_ALIGNED);
    end
  end

  // ********************
  // outputs
  // ********************
  assign link.par_data = par_data_reg;
  assign link.par_ovr = par_ovr_reg;
  assign link.sample_valid_strobe = strobe_reg;
  assign link.bit_clk = bit_clk_reg;
  assign link.frame = frame_reg;
  assign link.serial_lane_zero = lane0_sr_reg[13]; // msb leaves first
  assign link.serial_lane_one = lane1_sr_reg[13];
  assign sample_take = take_reg;
  assign mode_active = mode_reg;

endmodule : adc_conv_end

// [hw/adc_rcv_end.sv]
/*
  receiver end: samples the link with mclk, rebuilds sample words in order,
  averages eight samples and keeps the first 512 in a buffer.
  assumes mode matches the converter and the link is no faster than mclk/3 per edge.
*/
`timescale 1ns/1ps
`include "adc_consts.svh"

module adc_rcv_end
  import adc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire adc_mode_t mode,
  input wire logic [8:0] rd_addr,
  output logic [13:0] word_data,
  output logic word_ovr,
  output logic word_valid,
  output logic [15:0] eng_value,
  output logic [13:0] rd_data,
  output logic buf_full,
  adc_link_if.rcv link
);

  localparam int SW = 20;

  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic [2:0] prev_reg;
  logic s_strobe;
  logic s_clk;
  logic s_frame;
  logic clk_edge;
  logic frame_rise;
  logic frame_fall;
  logic strobe_rise;
  logic [13:0] lane0_sr_reg;
  logic [13:0] lane1_sr_reg;
  logic [13:0] pend_reg;
  logic pend_valid_reg;
  logic [13:0] word_reg;
  logic ovr_reg;
  logic valid_reg;
  logic [13:0] hist_reg [`ADC_AVG_DEPTH];
  logic [16:0] sum_reg;
  logic [15:0] eng_reg;
  logic [13:0] mem_reg [`ADC_BUF_DEPTH];
  logic [9:0] wr_ptr_reg;
  logic [13:0] rd_reg;

  // ********************
  // input synchroniser
  // ********************
  // every link wire takes two flops; frame passes the same depth as the data,
  // so it stays on the word boundary with no phase shift; the bit clock edges are what sit centred on the bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {link.par_ovr, link.sample_valid_strobe, link.bit_clk, link.frame,
        link.serial_lane_zero, link.serial_lane_one, link.par_data};
      sync2_reg <= sync1_reg;
    end
  end

  assign s_strobe = sync2_reg[18];
  assign s_clk = sync2_reg[17];
  assign s_frame = sync2_reg[16];

  // edge finder on the second stage only
  always_ff @(posedge mclk) begin
    if (reset) begin
      prev_reg <= 3'h0;
    end else begin
      prev_reg <= sync2_reg[18:16];
    end
  end

  assign clk_edge = s_clk ^ prev_reg[1];
  assign frame_rise = s_frame && !prev_reg[0];
  assign frame_fall = !s_frame && prev_reg[0];
  assign strobe_rise = s_strobe && !prev_reg[2];

  // ********************
  // lane shifters
  // ********************
  // one shift per edge of either polarity; the earliest bit ends at the top
  always_ff @(posedge mclk) begin
    if (reset) begin
      lane0_sr_reg <= 14'h0000;
      lane1_sr_reg <= 14'h0000;
    end else if (clk_edge) begin
      lane0_sr_reg <= {lane0_sr_reg[12:0], sync2_reg[15]};
      lane1_sr_reg <= {lane1_sr_reg[12:0], sync2_reg[14]};
    end
  end

  // ********************
  // word assembly
  // ********************
  // lane one is always the older sample; in aligned mode lane zero waits a cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      word_reg <= 14'h0000;
      ovr_reg <= 1'b0;
      valid_reg <= 1'b0;
      pend_reg <= 14'h0000;
      pend_valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      pend_valid_reg <= 1'b0;
      if (mode == ADC_MODE_PAR && strobe_rise) begin
        word_reg <= sync2_reg[13:0];
        ovr_reg <= sync2_reg[19];
        valid_reg <= 1'b1;
      end else if (mode == ADC_MODE_SINGLE && frame_rise) begin
        word_reg <= lane0_sr_reg;
        ovr_reg <= 1'b0;
        valid_reg <= 1'b1;
      end else if (mode != ADC_MODE_SINGLE && mode != ADC_MODE_PAR && frame_rise) begin
        word_reg <= lane1_sr_reg;
        ovr_reg <= 1'b0;
        valid_reg <= 1'b1;
        pend_reg <= lane0_sr_reg;
        pend_valid_reg <= (mode == ADC_MODE_DUAL_ALIGNED);
      end else if (mode == ADC_MODE_DUAL_OFFSET && frame_fall) begin
        word_reg <= lane0_sr_reg;
        valid_reg <= 1'b1;
      end else if (pend_valid_reg) begin
        word_reg <= pend_reg;
        valid_reg <= 1'b1;
      end
    end
  end

  // ********************
  // eight sample average
  // ********************
  // running sum avoids an adder tree at the cost of one history read per word
  always_ff @(posedge mclk) begin
    if (reset) begin
      sum_reg <= 17'h00000;
      eng_reg <= 16'h0000;
    end else begin
      if (valid_reg) begin
        sum_reg <= sum_reg + {3'h0, word_reg} - {3'h0, hist_reg[`ADC_AVG_DEPTH-1]};
      end
      eng_reg <= {2'h0, sum_reg[16:`ADC_AVG_SHIFT]} - `ADC_MIDSCALE;
    end
  end

  for (genvar i = 0; i < `ADC_AVG_DEPTH; i++) begin : g_hist
    always_ff @(posedge mclk) begin
      if (reset) begin
        hist_reg[i] <= 14'h0000;
      end else if (valid_reg) begin
        hist_reg[i] <= (i == 0) ? word_reg : hist_reg[(i == 0) ? 0 : i - 1];
      end
    end
  end

  // ********************
  // capture buffer
  // ********************
  // writing stops for good once 512 words are in; only reset rearms it
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ptr_reg <= 10'h000;
    end else if (valid_reg && !wr_ptr_reg[9]) begin
      wr_ptr_reg <= wr_ptr_reg + 10'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (valid_reg && !wr_ptr_reg[9]) begin
      mem_reg[wr_ptr_reg[8:0]] <= word_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_reg <= 14'h0000;
    end else begin
      rd_reg <= mem_reg[rd_addr];
    end
  end

  assign word_data = word_reg;
  assign word_ovr = ovr_reg;
  assign word_valid = valid_reg;
  assign eng_value = eng_reg;
  assign rd_data = rd_reg;
  assign buf_full = wr_ptr_reg[9];

endmodule : adc_rcv_end

// [dv/adc_link_checker.sv]
/*
  timing checks on the converter link wires: strobe shape, frame length,
  bit clock spacing and data placement against the bit clock.
  assumes the testbench instantiates it beside the link with mclk and reset.
*/
`timescale 1ns/1ps
module adc_link_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [13:0] par_data,
  input wire logic par_ovr,
  input wire logic sample_valid_strobe,
  input wire logic bit_clk,
  input wire logic frame,
  input wire logic serial_lane_zero,
  input wire logic serial_lane_one
);
  // ************
  // helper counters
  // ************
  logic [5:0] fr_cnt;
  logic [4:0] tog_cnt;
  logic started;

  // cycles of frame high, cleared while low
  always_ff @(posedge mclk) begin
    if (reset || !frame) begin
      fr_cnt <= 6'h00;
    end else begin
      fr_cnt <= fr_cnt + 6'h01;
    end
  end

  // bit clock edges per word; the first word has no predecessor, hence started
  always_ff @(posedge mclk) begin
    if (reset) begin
      tog_cnt <= 5'h00;
      started <= 1'b0;
    end else if ($rose(frame)) begin
      tog_cnt <= 5'h00;
      started <= 1'b1;
    end else if ($changed(bit_clk)) begin
      tog_cnt <= tog_cnt + 5'h01;
    end
  end

  // ************
  // properties
  // ************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  par_hold_a: assert property (
    $changed(par_data) |-> $fell(sample_valid_strobe)) else $error("parallel word moved off strobe fall");
  ovr_hold_a: assert property (
    $changed(par_ovr) |-> $fell(sample_valid_strobe)) else $error("over-range moved off strobe fall");
  strobe_high_a: assert property (
    $fell(sample_valid_strobe) |-> $past(sample_valid_strobe, 1) && $past(sample_valid_strobe, 2)
      && $past(sample_valid_strobe, 3)) else $error("strobe high phase too short");
  strobe_low_a: assert property (
    $rose(sample_valid_strobe) |-> !$past(sample_valid_strobe, 1) && !$past(sample_valid_strobe, 2)
      && !$past(sample_valid_strobe, 3)) else $error("strobe low phase too short");
  frame_len_a: assert property (
    $fell(frame) |-> fr_cnt == 6'h1C) else $error("frame marker not seven slots long");
  word_clks_a: assert property (
    $rose(frame) && started |-> tog_cnt == 5'h0E) else $error("word did not carry 14 clock edges");
  clk_slot_a: assert property (
    $changed(bit_clk) |=> $stable(bit_clk) [*3]) else $error("bit clock edges closer than a slot");
  lane0_slot_a: assert property (
    $changed(serial_lane_zero) |-> bit_clk == $past(bit_clk) && $past(bit_clk) == $past(bit_clk, 2))
    else $error("lane zero moved near a clock edge");
  lane1_slot_a: assert property (
    $changed(serial_lane_one) |-> bit_clk == $past(bit_clk) && $past(bit_clk) == $past(bit_clk, 2))
    else $error("lane one moved near a clock edge");

  strobe_run_c: cover property ($rose(sample_valid_strobe));
  frame_run_c: cover property ($rose(frame) && started);
  lane_one_c: cover property ($changed(serial_lane_one) && frame);
endmodule : adc_link_checker

// [dv/tb_top.sv]
/*
  testbench: both link ends joined, each output format run from reset,
  rebuilt words compared in conversion order, buffer, average and reset checked.
  assumes the design files and the link checker are compiled first.
*/
`timescale 1ns/1ps
module tb_top
  import adc_pkg::*;
;
  // ************
  // stimulus and observed signals
  // ************
  logic mclk = 1'b0;
  logic reset = 1'b1;
  adc_mode_t mode = ADC_MODE_PAR;
  logic [13:0] sdata = 14'h1000;
  logic sovr = 1'b0;
  logic [8:0] rd_addr = 9'h000;
  logic take, wovr, wvalid, bfull;
  adc_mode_t mact;
  logic [13:0] wdata, rdata, e;
  logic [15:0] eng;
  logic [16:0] sum;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int wcnt, nmatch, widx;
  logic [14:0] q[$];
  logic [14:0] qe;
  logic [13:0] hist[$];
  logic [13:0] emem[512];
  logic eok[512];
  adc_mode_t seq[4] = '{ADC_MODE_SINGLE, ADC_MODE_DUAL_ALIGNED, ADC_MODE_DUAL_OFFSET, ADC_MODE_PAR};

  adc_link_if link();
  adc_conv_end i_adc_conv_end (.mclk(mclk), .reset(reset), .mode(mode), .sample_data(sdata),
    .sample_ovr(sovr), .sample_take(take), .mode_active(mact), .link(link));
  adc_rcv_end i_adc_rcv_end (.mclk(mclk), .reset(reset), .mode(mode), .rd_addr(rd_addr),
    .word_data(wdata), .word_ovr(wovr), .word_valid(wvalid), .eng_value(eng), .rd_data(rdata),
    .buf_full(bfull), .link(link));
  adc_link_checker i_adc_link_checker (.mclk(mclk), .reset(reset), .par_data(link.par_data),
    .par_ovr(link.par_ovr), .sample_valid_strobe(link.sample_valid_strobe), .bit_clk(link.bit_clk),
    .frame(link.frame), .serial_lane_zero(link.serial_lane_zero),
    .serial_lane_one(link.serial_lane_one));

  // 200 MHz
  always #2.5 mclk = ~mclk;

  // ************
  // compare and access tasks
  // ************
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t value got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chk1

  // buffer read: address at one edge, data after the next
  task automatic rd_chk(input int a);
    @(posedge mclk);
    rd_addr <= a[8:0];
    @(posedge mclk);
    #1;
    if (eok[a]) chk16({2'h0, rdata}, {2'h0, emem[a]});
  endtask : rd_chk

  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  // scoreboard: samples queue at take, words pop in order; pre-edge values are read,
  // pop runs before push so a stale first word never matches a sample taken alongside it
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 12000) begin
      n_mismatch++;
      results();
    end
    if (reset) begin
      q.delete();
      wcnt = 0;
      nmatch = 0;
      widx = 0;
    end else begin
      if (wvalid) begin
        // the first words after reset may hold no sample yet; aligned dual mode
        // opens with a blank lane one word behind the two reset words
        if (wcnt < 4 && (q.size() == 0 || wdata !== q[0][13:0])) begin
          if (widx < 512) eok[widx] = 1'b0;
        end else begin
          qe = (q.size() > 0) ? q.pop_front() : {1'b0, ~wdata};
          e = qe[13:0];
          chk16({2'h0, wdata}, {2'h0, e});
          chk1(wovr, (mode == ADC_MODE_PAR) ? qe[14] : 1'b0);
          hist.push_back(e);
          if (hist.size() > 8) void'(hist.pop_front());
          if (widx < 512) begin
            emem[widx] = e;
            eok[widx] = 1'b1;
          end
          nmatch++;
        end
        wcnt++;
        widx++;
      end
      if (take) begin
        q.push_back({sovr, sdata});
        sdata <= sdata + 14'h0123;
        sovr <= ~sovr;
      end
    end
  end

  // ************
  // main sequence
  // ************
  initial begin
    // every format from a fresh reset, parallel last so its buffer stays for reads
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      reset <= 1'b1;
      mode <= seq[m];
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      repeat (seq[m] == ADC_MODE_PAR ? 3400 : 1200) @(posedge mclk);
      #1;
      chk1(mact === seq[m], 1'b1);
      chk1(nmatch >= (seq[m] == ADC_MODE_SINGLE ? 18 : 36), 1'b1);
    end
    // more than 512 words have passed: the first ones must survive
    chk1(bfull, 1'b1);
    rd_chk(1);
    rd_chk(2);
    rd_chk(255);
    rd_chk(511);
    // average of the last eight words less midscale
    @(posedge mclk iff wvalid);
    repeat (4) @(posedge mclk);
    #1;
    sum = 17'h00000;
    foreach (hist[i]) sum += {3'h0, hist[i]};
    chk16(eng, {2'h0, sum[16:3]} - 16'h2000);
    // reset in mid-run clears word and buffer state
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk16({2'h0, wdata}, 16'h0000);
    chk1(bfull, 1'b0);
    chk1(wvalid, 1'b0);
    results();
  end
endmodule : tb_top
